// ---- smp_pkg.sv ----
// Purpose: Constants and types for the stepper motion profile block
// Assumes: 200 MHz system clock, synchronous active-high reset
// Notes: Velocities in pulses per 10000 s; coil magnitudes 255 = full limit
//
// Contract
// - Full step: both coils about 70% of limit, one coil reverses per step.
// - Full step cycles four coil states, forward or back by direction.
// - Microstep modes move the current vector 1/2 to 1/32 full step.
// - Quarter step repeats every 16; states 3,7,11,15 equal full steps.
// - Quarter step states 1,5,9,13: one coil full, other coil zero.
// - Full variants accept full to 1/32; reduced variant up to 1/8 only.
// - Speed, velocity, acceleration counted in pulses regardless of step mode.
// - Speeds are unsigned, in pulses per ten thousand seconds.
// - Velocities are signed; sign is direction, magnitude is rate.
// - Pulse rate up to 50000/s; max speed setting capped at 500000000.
// - Max speed resets to the value for 200 pulses per second.
// - Accel and decel limit speed change per 10 ms interval.
// - Decel uses accel limit by default; option selects separate decel.
// - Changes within starting speed at both ends apply immediately.
// - First variant: slow, mixed, fast decay; resets to mixed.
// - Second variant: slow, mixed 25/50/75, fast; resets to mixed 50.
// - Reduced variant has no decay setting; driver chooses it.

package smp_pkg;

    // ==========================================================
    // Timing
    localparam longint CLK_HZ = 200_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = int'(CLK_HZ / 1000 * TICK_MS);
    localparam longint VEL_SECONDS = 10_000;
    localparam logic [47:0] PULSE_WRAP = 48'(VEL_SECONDS * CLK_HZ);

    // ==========================================================
    // Speed limits and reset values
    localparam logic [31:0] SPEED_CAP = 32'h1dcd_6500;
    localparam logic [31:0] RST_MAX_SPEED = 32'h001e_8480;
    localparam logic [31:0] RST_START_SPEED = 32'h0000_0000;
    localparam logic [31:0] RST_ACCEL = 32'h0000_9c40;
    localparam logic [31:0] RST_DECEL = 32'h0000_9c40;

    // ==========================================================
    // Variants, step modes, decay codes
    localparam logic [1:0] VAR_THREE = 2'h0;
    localparam logic [1:0] VAR_FIVE = 2'h1;
    localparam logic [1:0] VAR_REDUCED = 2'h2;

    localparam logic [2:0] MODE_FULL = 3'h0;
    localparam logic [2:0] MODE_EIGHTH = 3'h3;
    localparam logic [2:0] MODE_MAX = 3'h5;

    localparam logic [2:0] DEC3_SLOW = 3'h0;
    localparam logic [2:0] DEC3_MIXED = 3'h1;
    localparam logic [2:0] DEC3_FAST = 3'h2;
    localparam logic [2:0] DEC5_SLOW = 3'h0;
    localparam logic [2:0] DEC5_MIX50 = 3'h2;
    localparam logic [2:0] DEC5_FAST = 3'h4;
    localparam logic [2:0] DEC_NONE = 3'h0;

    // Phase in 1/32 step units, 128 per electrical turn
    localparam logic [6:0] FULL_OFS = 7'h10;
    localparam logic [6:0] FINE_STEP = 7'h20;
    localparam logic [5:0] QTR_TURN = 6'h20;

    typedef struct packed {
        logic [31:0] max_speed;
        logic [31:0] start_speed;
        logic [31:0] max_accel;
        logic [31:0] max_decel;
        logic use_accel;
        logic [2:0] step_mode;
        logic [2:0] decay;
    } smp_cfg_t;

    typedef struct packed {
        logic neg;
        logic [7:0] mag;
    } smp_coil_t;

endpackage

// ---- smp_motion.sv ----
// Purpose: Velocity ramp, step pulse generation and coil set-points
// Assumes: Inputs synchronous to clk; one clock domain
// Notes: VARIANT picks decay and step-mode support
`timescale 1ns/1ps
`default_nettype none

module smp_motion #(
    parameter logic [1:0] VARIANT = smp_pkg::VAR_THREE,
    parameter int TICK_CYCLES = smp_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration
    input wire smp_pkg::smp_cfg_t cfg_in,
    input wire logic cfg_load,
    // Command
    input wire logic signed [31:0] target_vel,
    // Motor driver side
    output logic step_pulse,
    output logic step_dir,
    output smp_pkg::smp_coil_t coil_a,
    output smp_pkg::smp_coil_t coil_b,
    output logic [2:0] decay_mode,
    // Status
    output logic signed [31:0] cur_vel,
    output logic [2:0] step_mode,
    output logic cfg_rejected
);

    // ==========================================================
    // Sine quarter table, 255 = full current limit
    function automatic logic [7:0] sine_q(input logic [5:0] k);
        case (k)
            6'h00: sine_q = 8'h00;
            6'h01: sine_q = 8'h0d;
            6'h02: sine_q = 8'h19;
            6'h03: sine_q = 8'h25;
            6'h04: sine_q = 8'h32;
            6'h05: sine_q = 8'h3e;
            6'h06: sine_q = 8'h4a;
            6'h07: sine_q = 8'h56;
            6'h08: sine_q = 8'h62;
            6'h09: sine_q = 8'h6d;
            6'h0a: sine_q = 8'h78;
            6'h0b: sine_q = 8'h83;
            6'h0c: sine_q = 8'h8e;
            6'h0d: sine_q = 8'h98;
            6'h0e: sine_q = 8'ha2;
            6'h0f: sine_q = 8'hab;
            6'h10: sine_q = 8'hb4;
            6'h11: sine_q = 8'hbd;
            6'h12: sine_q = 8'hc5;
            6'h13: sine_q = 8'hcd;
            6'h14: sine_q = 8'hd4;
            6'h15: sine_q = 8'hdb;
            6'h16: sine_q = 8'he1;
            6'h17: sine_q = 8'he7;
            6'h18: sine_q = 8'hec;
            6'h19: sine_q = 8'hf0;
            6'h1a: sine_q = 8'hf4;
            6'h1b: sine_q = 8'hf7;
            6'h1c: sine_q = 8'hfa;
            6'h1d: sine_q = 8'hfc;
            6'h1e: sine_q = 8'hfe;
            default: sine_q = 8'hff;
        endcase
    endfunction

    function automatic logic [2:0] decay_reset();
        case (VARIANT)
            smp_pkg::VAR_THREE: decay_reset = smp_pkg::DEC3_MIXED;
            smp_pkg::VAR_FIVE: decay_reset = smp_pkg::DEC5_MIX50;
            default: decay_reset = smp_pkg::DEC_NONE;
        endcase
    endfunction

    // ==========================================================
    // Configuration registers
    smp_pkg::smp_cfg_t cfg;
    smp_pkg::smp_cfg_t next_cfg;
    logic next_rejected;

    always_comb begin
        next_cfg = cfg;
        next_rejected = 1'b0;
        if (cfg_load) begin
            next_cfg.start_speed = cfg_in.start_speed;
            next_cfg.max_accel = cfg_in.max_accel;
            next_cfg.max_decel = cfg_in.max_decel;
            next_cfg.use_accel = cfg_in.use_accel;
            if (cfg_in.max_speed > smp_pkg::SPEED_CAP) begin
                next_cfg.max_speed = smp_pkg::SPEED_CAP;
            end else begin
                next_cfg.max_speed = cfg_in.max_speed;
            end
            // Unsupported resolution keeps the old one
            if (cfg_in.step_mode > smp_pkg::MODE_MAX ||
                (VARIANT == smp_pkg::VAR_REDUCED &&
                 cfg_in.step_mode > smp_pkg::MODE_EIGHTH)) begin
                next_rejected = 1'b1;
            end else begin
                next_cfg.step_mode = cfg_in.step_mode;
            end
            case (VARIANT)
                smp_pkg::VAR_THREE: begin
                    if (cfg_in.decay > smp_pkg::DEC3_FAST) begin
                        next_rejected = 1'b1;
                    end else begin
                        next_cfg.decay = cfg_in.decay;
                    end
                end
                smp_pkg::VAR_FIVE: begin
                    if (cfg_in.decay > smp_pkg::DEC5_FAST) begin
                        next_rejected = 1'b1;
                    end else begin
                        next_cfg.decay = cfg_in.decay;
                    end
                end
                default: begin
                    next_cfg.decay = smp_pkg::DEC_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg.max_speed <= smp_pkg::RST_MAX_SPEED;
            cfg.start_speed <= smp_pkg::RST_START_SPEED;
            cfg.max_accel <= smp_pkg::RST_ACCEL;
            cfg.max_decel <= smp_pkg::RST_DECEL;
            cfg.use_accel <= 1'b1;
            cfg.step_mode <= smp_pkg::MODE_FULL;
            cfg.decay <= decay_reset();
            cfg_rejected <= 1'b0;
        end else begin
            cfg <= next_cfg;
            cfg_rejected <= next_rejected;
        end
    end

    assign decay_mode = cfg.decay;
    assign step_mode = cfg.step_mode;

    // ==========================================================
    // Velocity ramp, one limited step per 10 ms tick
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic signed [31:0] next_cur_vel;
    logic [33:0] abs_cur;
    logic [33:0] abs_req;
    logic [33:0] abs_tgt;
    logic [33:0] dec_lim;
    logic [33:0] mag;
    logic signed [33:0] tgt;
    logic neg;
    logic tick;

    always_comb begin
        next_tick_cnt = tick_cnt + 32'h1;
        tick = 1'b0;
        if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 32'h0;
            tick = 1'b1;
        end
    end

    always_comb begin
        // Signed target, magnitude clamped before ramping
        abs_cur = cur_vel[31] ? 34'(-34'(cur_vel)) : 34'(cur_vel);
        abs_req = target_vel[31] ? 34'(-34'(target_vel)) : 34'(target_vel);
        abs_tgt = abs_req;
        if (abs_req > 34'(cfg.max_speed)) begin
            abs_tgt = 34'(cfg.max_speed);
        end
        tgt = target_vel[31] ? -$signed(abs_tgt) : $signed(abs_tgt);
        dec_lim = cfg.use_accel ? 34'(cfg.max_accel) : 34'(cfg.max_decel);
        neg = (cur_vel == 32'sh0) ? target_vel[31] : cur_vel[31];
        mag = abs_cur;
        next_cur_vel = cur_vel;
        if (abs_cur <= 34'(cfg.start_speed) && abs_tgt <= 34'(cfg.start_speed)) begin
            next_cur_vel = 32'(tgt);
        end else if (tick && cur_vel != 32'(tgt)) begin
            if (cur_vel != 32'sh0 && (cur_vel[31] != target_vel[31] || abs_tgt == 34'h0)) begin
                // Reversal: slow to zero first
                mag = (abs_cur > dec_lim) ? abs_cur - dec_lim : 34'h0;
            end else if (abs_tgt < abs_cur) begin
                mag = (abs_cur - abs_tgt > dec_lim) ? abs_cur - dec_lim : abs_tgt;
            end else begin
                mag = (abs_tgt - abs_cur > 34'(cfg.max_accel)) ?
                      abs_cur + 34'(cfg.max_accel) : abs_tgt;
            end
            next_cur_vel = neg ? 32'(-$signed(mag)) : 32'(mag);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt <= 32'h0;
            cur_vel <= 32'sh0;
        end else begin
            tick_cnt <= next_tick_cnt;
            cur_vel <= next_cur_vel;
        end
    end

    // ==========================================================
    // Pulse accumulator and microstep phase
    // Counts pulses; resolution only sets phase stride
    logic [47:0] pacc;
    logic [47:0] next_pacc;
    logic [6:0] phase;
    logic [6:0] next_phase;
    logic [6:0] aligned;
    logic [6:0] stride;
    logic next_pulse;
    logic next_dir;
    smp_pkg::smp_coil_t next_a;
    smp_pkg::smp_coil_t next_b;
    logic [7:0] s_lo;
    logic [7:0] s_hi;

    always_comb begin
        // Rate of |cur_vel| per 10000 s wraps PULSE_WRAP per pulse
        next_pacc = pacc + 48'(abs_cur);
        next_pulse = 1'b0;
        if (next_pacc >= smp_pkg::PULSE_WRAP) begin
            next_pacc = next_pacc - smp_pkg::PULSE_WRAP;
            next_pulse = 1'b1;
        end
        next_dir = cur_vel[31];
        stride = smp_pkg::FINE_STEP >> cfg.step_mode;
        if (cfg.step_mode == smp_pkg::MODE_FULL) begin
            // Full step sits on the diagonals only
            aligned = {phase[6:5], 5'h0} | smp_pkg::FULL_OFS;
        end else begin
            aligned = phase & ~(stride - 7'h1);
        end
        next_phase = aligned;
        if (next_pulse) begin
            next_phase = next_dir ? aligned - stride : aligned + stride;
        end
    end

    always_comb begin
        // A is cosine, B is sine of the phase angle
        s_lo = sine_q({1'b0, phase[4:0]});
        s_hi = sine_q(smp_pkg::QTR_TURN - {1'b0, phase[4:0]});
        case (phase[6:5])
            2'h0: begin
                next_a = '{neg: 1'b0, mag: s_hi};
                next_b = '{neg: 1'b0, mag: s_lo};
            end
            2'h1: begin
                next_a = '{neg: 1'b1, mag: s_lo};
                next_b = '{neg: 1'b0, mag: s_hi};
            end
            2'h2: begin
                next_a = '{neg: 1'b1, mag: s_hi};
                next_b = '{neg: 1'b1, mag: s_lo};
            end
            default: begin
                next_a = '{neg: 1'b0, mag: s_lo};
                next_b = '{neg: 1'b1, mag: s_hi};
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pacc <= 48'h0;
            phase <= 7'h0;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
            coil_a <= '0;
            coil_b <= '0;
        end else begin
            pacc <= next_pacc;
            phase <= next_phase;
            step_pulse <= next_pulse;
            step_dir <= next_dir;
            coil_a <= next_a;
            coil_b <= next_b;
        end
    end

endmodule

`default_nettype wire

// ---- smp_motion_assertions.sv ----
// Purpose: Port checks for smp_motion
// Assumes: One clock, synchronous reset
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module smp_motion_chk #(
    parameter logic [1:0] VARIANT = smp_pkg::VAR_THREE,
    parameter int TICK_CYCLES = smp_pkg::TICK_CYC
) (
    // Clock and inputs
    input wire logic clk,
    input wire logic sys_rst,
    input wire smp_pkg::smp_cfg_t cfg_in,
    input wire logic cfg_load,
    input wire logic signed [31:0] target_vel,
    // Outputs watched
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire smp_pkg::smp_coil_t coil_a,
    input wire smp_pkg::smp_coil_t coil_b,
    input wire logic [2:0] decay_mode,
    input wire logic signed [31:0] cur_vel,
    input wire logic [2:0] step_mode,
    input wire logic cfg_rejected
);
    // ==========
    // Variant limits
    localparam logic [2:0] MMAX = VARIANT == smp_pkg::VAR_REDUCED ?
        smp_pkg::MODE_EIGHTH : smp_pkg::MODE_MAX;
    localparam logic [2:0] DRST = VARIANT == smp_pkg::VAR_FIVE ? smp_pkg::DEC5_MIX50 :
        VARIANT == smp_pkg::VAR_THREE ? smp_pkg::DEC3_MIXED : smp_pkg::DEC_NONE;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // Properties
    a_pulse_single: assert property (
        step_pulse |=> !step_pulse) else $error("step pulse too long");
    a_reset_vals: assert property (
        $past(sys_rst) |-> decay_mode == DRST && step_mode == smp_pkg::MODE_FULL
        && cur_vel == 0) else $error("bad reset values");
    a_full_level: assert property (
        step_pulse && step_mode == 3'h0 && $past(step_mode, 3) == 3'h0 |=>
        coil_a.mag == 8'hb4 && coil_b.mag == 8'hb4) else $error("full step level");
    a_full_flip: assert property (
        step_pulse && step_mode == 3'h0 && $past(step_mode, 3) == 3'h0 |=>
        (coil_a.neg != $past(coil_a.neg)) != (coil_b.neg != $past(coil_b.neg)))
        else $error("full step flip");
    a_mode_reject: assert property (
        cfg_load && cfg_in.step_mode > MMAX |=> cfg_rejected && $stable(step_mode))
        else $error("bad mode taken");
    a_mode_accept: assert property (
        cfg_load && cfg_in.step_mode <= MMAX && cfg_in.decay == 3'h0 |=>
        !cfg_rejected && step_mode == $past(cfg_in.step_mode)) else $error("mode lost");
    a_dir_sign: assert property (
        step_pulse && $past(cur_vel) != 0 |-> step_dir == $past(cur_vel[31]))
        else $error("direction wrong");
    a_speed_cap: assert property (
        cur_vel <= $signed(smp_pkg::SPEED_CAP) && cur_vel >= -$signed(smp_pkg::SPEED_CAP))
        else $error("speed above cap");
    c_pulse: cover property (step_pulse);
    c_reject: cover property (cfg_rejected);
    c_reverse: cover property (step_pulse && step_dir);
    c_target_neg: cover property (target_vel < 0 && step_pulse && step_dir);
endmodule
bind smp_motion smp_motion_chk #(.VARIANT(VARIANT), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .cfg_in(cfg_in), .cfg_load(cfg_load),
    .target_vel(target_vel), .step_pulse(step_pulse), .step_dir(step_dir),
    .coil_a(coil_a), .coil_b(coil_b), .decay_mode(decay_mode), .cur_vel(cur_vel),
    .step_mode(step_mode), .cfg_rejected(cfg_rejected));
`default_nettype wire

// ---- smp_coil_model.sv ----
// Purpose: Behavioural coil driver at the far side
// Assumes: Pulses are one cycle wide
// Notes: Rotor position is a signed pulse count
`timescale 1ns/1ps
`default_nettype none
module smp_coil_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Step inputs
    input wire logic step_pulse,
    input wire logic step_dir,
    // Observed state
    output var int pulses,
    output var int position
);
    // ==========
    // Counting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulses <= 0;
            position <= 0;
        end else if (step_pulse) begin
            pulses <= pulses + 1;
            position <= step_dir ? position - 1 : position + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for smp_motion
// Assumes: Tick shortened to 20 cycles
// Notes: Pulses at the cap come every 4000 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========
    // Signals
    localparam int TICK = 20;
    logic clk;
    logic sys_rst;
    smp_pkg::smp_cfg_t cfg_in;
    logic cfg_load;
    logic signed [31:0] target_vel;
    logic step_pulse;
    logic step_dir;
    smp_pkg::smp_coil_t coil_a;
    smp_pkg::smp_coil_t coil_b;
    logic [2:0] decay_mode;
    logic signed [31:0] cur_vel;
    logic [2:0] step_mode;
    logic cfg_rejected;
    logic [2:0] decay5;
    logic [2:0] decay_r;
    logic [2:0] mode_r;
    logic rej5;
    logic rej_r;
    int pulses;
    int position;
    int failures;
    int n_checks;
    int p;
    logic signed [31:0] prev;
    logic [1:0] s [0:4];

    smp_motion #(.VARIANT(smp_pkg::VAR_THREE), .TICK_CYCLES(TICK)) uut (
        .clk(clk), .sys_rst(sys_rst), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .target_vel(target_vel), .step_pulse(step_pulse), .step_dir(step_dir),
        .coil_a(coil_a), .coil_b(coil_b), .decay_mode(decay_mode), .cur_vel(cur_vel),
        .step_mode(step_mode), .cfg_rejected(cfg_rejected));
    smp_coil_model drv (.clk(clk), .sys_rst(sys_rst), .step_pulse(step_pulse),
        .step_dir(step_dir), .pulses(pulses), .position(position));
    // Other variants share the stimulus; only config outputs watched
    smp_motion #(.VARIANT(smp_pkg::VAR_FIVE), .TICK_CYCLES(TICK)) uut_five (
        .clk(clk), .sys_rst(sys_rst), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .target_vel(target_vel), .step_pulse(), .step_dir(), .coil_a(), .coil_b(),
        .decay_mode(decay5), .cur_vel(), .step_mode(), .cfg_rejected(rej5));
    smp_motion #(.VARIANT(smp_pkg::VAR_REDUCED), .TICK_CYCLES(TICK)) uut_red (
        .clk(clk), .sys_rst(sys_rst), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .target_vel(target_vel), .step_pulse(), .step_dir(), .coil_a(), .coil_b(),
        .decay_mode(decay_r), .cur_vel(), .step_mode(mode_r), .cfg_rejected(rej_r));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========
    // Tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic load(input logic [31:0] mx, st, ac, dc, input logic ua,
        input logic [2:0] md, dm);
        @(posedge clk);
        cfg_in <= '{mx, st, ac, dc, ua, md, dm};
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        #1;
    endtask

    task automatic target(input logic signed [31:0] v);
        @(posedge clk);
        target_vel <= v;
        #1;
    endtask

    // Bounded so a stuck ramp ends in a mismatch, not a hang
    task automatic wait_chg();
        int k;
        prev = cur_vel;
        k = 0;
        while (cur_vel === prev && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    task automatic pulse_wait(input int n);
        int k;
        int p0;
        p0 = pulses;
        k = 0;
        while (pulses < p0 + n && k < 5000 * n) begin
            @(posedge clk);
            #1;
            k++;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("watchdog expired");
        test_done();
    end

    // ==========
    // Tests
    initial begin
        sys_rst = 1'b1;
        cfg_in = '0;
        cfg_load = 1'b0;
        target_vel = '0;
        failures = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("decay", decay_mode, smp_pkg::DEC3_MIXED);
        chk("coils", {coil_a.mag, coil_b.mag}, 16'hb4b4);
        chk("decay5", decay5, smp_pkg::DEC5_MIX50);
        chk("decay_red", decay_r, smp_pkg::DEC_NONE);
        $display("test reset done");
        target(32'sd50000000);
        wait_chg();
        chk("ramp1", cur_vel, 32'd40000);
        wait_chg();
        chk("ramp2", cur_vel, 32'd80000);
        repeat (60 * TICK) @(posedge clk);
        #1;
        chk("max", cur_vel, 32'd2000000);
        load(32'd2000000, 0, 32'd100000, 32'd10000, 1'b1, 3'h0, 3'h1);
        target(0);
        wait_chg();
        chk("dec1", cur_vel, prev - 32'd100000);
        load(32'd2000000, 0, 32'd100000, 32'd10000, 1'b0, 3'h0, 3'h1);
        wait_chg();
        chk("dec2", cur_vel, prev - 32'd10000);
        $display("test ramp done");
        for (int i = 0; i < 8; i++) begin
            load(32'd2000000, 0, 32'd100000, 32'd10000, 1'b0, 3'(i), 3'(i));
            chk("reject", cfg_rejected, i > 2);
            chk("mode", step_mode, i > 5 ? 5 : i);
            chk("decay", decay_mode, i > 2 ? 2 : i);
            chk("reject5", rej5, i > 4);
            chk("decay5", decay5, i > 4 ? 4 : i);
            chk("reject_red", rej_r, i > 3);
            chk("mode_red", mode_r, i > 3 ? 3 : i);
            chk("decay_red", decay_r, 3'h0);
        end
        $display("test config done");
        load(32'd600000000, 32'd600000000, 32'd100000, 32'd10000, 1'b1, 3'h0, 3'h1);
        target(32'sd700000000);
        repeat (2) @(posedge clk);
        #1;
        chk("clamp", cur_vel, 32'd500000000);
        for (int k = 0; k < 5; k++) begin
            pulse_wait(1);
            s[k] = {coil_a.neg, coil_b.neg};
        end
        chk("cycle", s[4], s[0]);
        chk("half turn", s[2] ^ s[0], 2'b11);
        // Exact period at the cap: 16000 cycles hold exactly four pulses
        p = pulses;
        repeat (16000) @(posedge clk);
        #1;
        chk("rate", pulses - p, 32'd4);
        target(-32'sd700000000);
        p = position;
        pulse_wait(1);
        chk("dir", step_dir, 1'b1);
        chk("back", {coil_a.neg, coil_b.neg}, s[3]);
        chk("pos", position, p - 1);
        $display("test full step done");
        load(32'd600000000, 32'd600000000, 32'd100000, 32'd10000, 1'b1, 3'h2, 3'h1);
        pulse_wait(2);
        chk("qtr edge", {coil_a.mag ^ coil_b.mag, coil_a.mag & coil_b.mag}, 16'hff00);
        pulse_wait(2);
        chk("qtr full", {coil_a.mag, coil_b.mag}, 16'hb4b4);
        $display("test quarter done");
        test_done();
    end
endmodule
`default_nettype wire
